// *** inc/efmb_pkg.sv ***
/*
 * Constants, carrier types and state codes for the event flag and mask bank.
 * Assumes one 50 MHz clock domain and on-chip event sources on that clock.
 */
package efmb_pkg;

    // ==========================================================
    // Register offsets on the serial bus
    localparam logic [7:0] ADDR_FLAG0 = 8'h03;
    localparam logic [7:0] ADDR_FAULT_THERMAL_EVENT_FLAGS = 8'h04;
    localparam logic [7:0] ADDR_CONVERTER_EVENT_FLAGS = 8'h05;
    localparam logic [7:0] ADDR_TIMER_FAULT_EVENT_FLAGS = 8'h06;
    localparam logic [7:0] ADDR_CHARGE_EVENT_MASKS = 8'h07;
    localparam logic [7:0] ADDR_FAULT_THERMAL_EVENT_MASKS = 8'h08;
    localparam logic [7:0] ADDR_MASK2 = 8'h09;
    localparam logic [7:0] ADDR_MASK3 = 8'h0A;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_FLAG  = 8'h00;
    localparam logic [7:0] RST_CHARGE_EVENT_MASKS = 8'h00;
    localparam logic [7:0] RST_FAULT_THERMAL_EVENT_MASKS = 8'h00;
    localparam logic [7:0] RST_MASK2 = 8'h71;
    localparam logic [7:0] RST_MASK3 = 8'h00;
    localparam logic [7:0] RST_PTR   = 8'h00;

    // ==========================================================
    // Flag bit positions
    localparam int B_OVP       = 7;
    localparam int B_BAT_OCP   = 5;
    localparam int B_BAT_UV    = 4;
    localparam int B_TS_COLD   = 3;
    localparam int B_TS_HOT    = 0;
    localparam int B_ADC_DONE  = 7;
    localparam int B_COMP_ONE  = 6;
    localparam int B_COMP_LAST = 4;
    localparam int B_TS_OPEN   = 0;
    localparam int B_WDOG      = 6;
    localparam int B_SAFETY    = 5;
    localparam int B_REG_OCP   = 4;
    localparam int B_ILIM_OPEN = 3;
    localparam int B_WAKE_ONE  = 2;
    localparam int B_WAKE_TWO  = 1;
    localparam int B_RST_WARN  = 0;
    localparam int B_CHG_TOP   = 6;

    // ==========================================================
    // Serial bus constants
    localparam logic [6:0] DEV_ADDR      = 7'h6B;  // Arbitrary bus address
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] CNT_ZERO      = 4'h0;
    localparam logic [3:0] CNT_ONE       = 4'h1;
    localparam logic [7:0] PTR_STEP      = 8'h01;

    // Event inputs from the on-chip detectors
    typedef struct packed {
        logic [6:0] charge;      // Pulses: taper, done, ilim, path, vin reg, thermal, pgood
        logic       ovp;         // Pulse
        logic       bat_ocp;     // Pulse
        logic       bat_uv;      // Pulse
        logic [3:0] ts_region;   // Levels: cold, cool, warm, hot
        logic       adc_done;    // Pulse
        logic [2:0] comp_above;  // Levels: measurement above threshold
        logic [2:0] comp_dir;    // Levels: 1 alarm above, 0 alarm below
        logic       ts_open;
        logic       wdog;
        logic       safety;
        logic       reg_ocp;
        logic       ilim_open;
        logic       wake_one;
        logic       wake_two;
        logic       rst_warn;
    } efmb_evt_t;

    // Serial bus states
    typedef enum logic [6:0] {
        ST_IDLE     = 7'h01,
        ST_ADDR     = 7'h02,
        ST_ADDR_ACK = 7'h04,
        ST_WR       = 7'h08,
        ST_WR_ACK   = 7'h10,
        ST_RD       = 7'h20,
        ST_RD_ACK   = 7'h40
    } efmb_state_t;

endpackage

// *** core/efmb_top.sv ***
/*
 * Event flag and interrupt mask bank with its two-wire serial slave.
 * Assumes event inputs come from logic on i_ref_clk; SCL and SDA are pins.
 */
`timescale 1ns/1ns

module efmb_top
    import efmb_pkg::*;
(
    input  wire logic      i_ref_clk,
    input  wire logic      i_rstn,
    input  wire efmb_evt_t i_evt,
    input  wire logic      i_scl,
    input  wire logic      i_sda,
    output logic           o_sda_out,
    output logic           o_sda_oe_n,
    output logic           o_int_n
);

    // ==========================================================
    // Pin synchronisers
    logic        scl_s1_q, scl_s2_q, scl_s3_q;
    logic        sda_s1_q, sda_s2_q, sda_s3_q;
    logic        scl_rise, scl_fall, bus_start, bus_stop;

    // Two flops per pin, third stage for edge detection
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
        end else begin
            scl_s1_q <= i_scl;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= i_sda;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
        end
    end

    // Bus conditions from synchronised levels
    assign scl_rise  = scl_s2_q & ~scl_s3_q;
    assign scl_fall  = ~scl_s2_q & scl_s3_q;
    assign bus_start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
    assign bus_stop  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

    // ==========================================================
    // Register storage
    logic [7:0]  flag0_q, fault_thermal_event_flags_q, converter_event_flags_q, timer_fault_event_flags_q;
    logic [7:0]  flag0_d, fault_thermal_event_flags_d, converter_event_flags_d, timer_fault_event_flags_d;
    logic [7:0]  charge_event_masks_q, fault_thermal_event_masks_q, mask2_q, mask3_q;
    logic [7:0]  charge_event_masks_d, fault_thermal_event_masks_d, mask2_d, mask3_d;
    logic [3:0]  region_q;
    logic [2:0]  comp_met_q, comp_met;
    logic        int_n_d;
    logic [7:0]  rd_data;
    logic [7:0]  set0, set1, set2, set3;

    // ==========================================================
    // Serial slave state
    efmb_state_t st_q, st_d;
    logic [3:0]  cnt_q, cnt_d;
    logic [7:0]  shr_q, shr_d;
    logic [7:0]  ptr_q, ptr_d;
    logic        first_q, first_d;
    logic        rw_q, rw_d;
    logic        oe_n_q, oe_n_d;
    logic        wr_stb, rd_stb;

    // Read data selected by the register pointer
    always_comb begin
        unique case (ptr_q)
            ADDR_FLAG0: rd_data = flag0_q;
            ADDR_FAULT_THERMAL_EVENT_FLAGS: rd_data = fault_thermal_event_flags_q;
            ADDR_CONVERTER_EVENT_FLAGS: rd_data = converter_event_flags_q;
            ADDR_TIMER_FAULT_EVENT_FLAGS: rd_data = timer_fault_event_flags_q;
            ADDR_CHARGE_EVENT_MASKS: rd_data = charge_event_masks_q;
            ADDR_FAULT_THERMAL_EVENT_MASKS: rd_data = fault_thermal_event_masks_q;
            ADDR_MASK2: rd_data = mask2_q;
            ADDR_MASK3: rd_data = mask3_q;
            default:    rd_data = 8'h00;  // Unmapped reads as zero
        endcase
    end

    // Next state of the serial slave
    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        shr_d   = shr_q;
        ptr_d   = ptr_q;
        first_d = first_q;
        rw_d    = rw_q;
        oe_n_d  = oe_n_q;
        wr_stb  = 1'b0;
        rd_stb  = 1'b0;
        if (bus_stop) begin
            st_d   = ST_IDLE;
            oe_n_d = 1'b1;
        end else if (bus_start) begin
            st_d   = ST_ADDR;
            cnt_d  = CNT_ZERO;
            oe_n_d = 1'b1;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    oe_n_d = 1'b1;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        shr_d = {shr_q[6:0], sda_s2_q};
                        cnt_d = cnt_q + CNT_ONE;
                    end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                        if (shr_q[7:1] == DEV_ADDR) begin
                            rw_d   = shr_q[0];
                            oe_n_d = 1'b0;
                            st_d   = ST_ADDR_ACK;
                        end else begin
                            st_d = ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        cnt_d = CNT_ZERO;
                        if (rw_q) begin
                            rd_stb = 1'b1;
                            shr_d  = rd_data;
                            oe_n_d = rd_data[7];
                            ptr_d  = ptr_q + PTR_STEP;
                            st_d   = ST_RD;
                        end else begin
                            oe_n_d  = 1'b1;
                            first_d = 1'b1;
                            st_d    = ST_WR;
                        end
                    end
                end
                ST_WR: begin
                    if (scl_rise) begin
                        shr_d = {shr_q[6:0], sda_s2_q};
                        cnt_d = cnt_q + CNT_ONE;
                    end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                        oe_n_d  = 1'b0;
                        first_d = 1'b0;
                        st_d    = ST_WR_ACK;
                        if (first_q) begin
                            ptr_d = shr_q;
                        end else begin
                            wr_stb = 1'b1;
                            ptr_d  = ptr_q + PTR_STEP;
                        end
                    end
                end
                ST_WR_ACK: begin
                    if (scl_fall) begin
                        oe_n_d = 1'b1;
                        cnt_d  = CNT_ZERO;
                        st_d   = ST_WR;
                    end
                end
                ST_RD: begin
                    if (scl_rise) begin
                        cnt_d = cnt_q + CNT_ONE;
                    end else if (scl_fall) begin
                        if (cnt_q == BITS_PER_BYTE) begin
                            oe_n_d = 1'b1;
                            st_d   = ST_RD_ACK;
                        end else begin
                            shr_d  = {shr_q[6:0], 1'b0};
                            oe_n_d = shr_q[6];
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise && sda_s2_q) begin
                        st_d = ST_IDLE;  // Host refused further bytes
                    end else if (scl_fall) begin
                        rd_stb = 1'b1;
                        shr_d  = rd_data;
                        oe_n_d = rd_data[7];
                        ptr_d  = ptr_q + PTR_STEP;
                        cnt_d  = CNT_ZERO;
                        st_d   = ST_RD;
                    end
                end
                default: begin
                    st_d   = ST_IDLE;
                    oe_n_d = 1'b1;
                end
            endcase
        end
    end

    // Serial slave registers
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            st_q      <= ST_IDLE;
            cnt_q     <= CNT_ZERO;
            shr_q     <= 8'h00;
            ptr_q     <= RST_PTR;
            first_q   <= 1'b0;
            rw_q      <= 1'b0;
            oe_n_q    <= 1'b1;
            o_sda_out <= 1'b0;
        end else begin
            st_q      <= st_d;
            cnt_q     <= cnt_d;
            shr_q     <= shr_d;
            ptr_q     <= ptr_d;
            first_q   <= first_d;
            rw_q      <= rw_d;
            oe_n_q    <= oe_n_d;
            o_sda_out <= 1'b0;
        end
    end

    assign o_sda_oe_n = oe_n_q;

    // ==========================================================
    // Flag set, clear-on-read and mask writes
    always_comb begin
        comp_met = ~(i_evt.comp_above ^ i_evt.comp_dir);
        set0 = 8'h00;
        set0[B_CHG_TOP:0] = i_evt.charge;
        set1 = 8'h00;
        set1[B_OVP] = i_evt.ovp;
        set1[B_BAT_OCP] = i_evt.bat_ocp;
        set1[B_BAT_UV] = i_evt.bat_uv;
        set1[B_TS_COLD:B_TS_HOT] = i_evt.ts_region & ~region_q;
        set2 = 8'h00;
        set2[B_ADC_DONE] = i_evt.adc_done;
        set2[B_COMP_ONE:B_COMP_LAST] = comp_met & ~comp_met_q;
        set2[B_TS_OPEN] = i_evt.ts_open;
        set3 = 8'h00;
        set3[B_WDOG] = i_evt.wdog;
        set3[B_SAFETY] = i_evt.safety;
        set3[B_REG_OCP] = i_evt.reg_ocp;
        set3[B_ILIM_OPEN] = i_evt.ilim_open;
        set3[B_WAKE_ONE] = i_evt.wake_one;
        set3[B_WAKE_TWO] = i_evt.wake_two;
        set3[B_RST_WARN] = i_evt.rst_warn;
        flag0_d = ((rd_stb && ptr_q == ADDR_FLAG0) ? 8'h00 : flag0_q) | set0;
        fault_thermal_event_flags_d = ((rd_stb && ptr_q == ADDR_FAULT_THERMAL_EVENT_FLAGS) ? 8'h00 : fault_thermal_event_flags_q) | set1;
        converter_event_flags_d = ((rd_stb && ptr_q == ADDR_CONVERTER_EVENT_FLAGS) ? 8'h00 : converter_event_flags_q) | set2;
        timer_fault_event_flags_d = ((rd_stb && ptr_q == ADDR_TIMER_FAULT_EVENT_FLAGS) ? 8'h00 : timer_fault_event_flags_q) | set3;
        // charge mask write, bit 7 included
        charge_event_masks_d = (wr_stb && ptr_q == ADDR_CHARGE_EVENT_MASKS) ? shr_q : charge_event_masks_q;
        fault_thermal_event_masks_d = (wr_stb && ptr_q == ADDR_FAULT_THERMAL_EVENT_MASKS) ? shr_q : fault_thermal_event_masks_q;
        mask2_d = (wr_stb && ptr_q == ADDR_MASK2) ? shr_q : mask2_q;
        mask3_d = (wr_stb && ptr_q == ADDR_MASK3) ? shr_q : mask3_q;
        int_n_d = ~|((flag0_q & ~charge_event_masks_q) | (fault_thermal_event_flags_q & ~fault_thermal_event_masks_q)
                   | (converter_event_flags_q & ~mask2_q) | (timer_fault_event_flags_q & ~mask3_q));
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            flag0_q    <= RST_FLAG;
            fault_thermal_event_flags_q    <= RST_FLAG;
            converter_event_flags_q    <= RST_FLAG;
            timer_fault_event_flags_q    <= RST_FLAG;
            charge_event_masks_q    <= RST_CHARGE_EVENT_MASKS;
            fault_thermal_event_masks_q    <= RST_FAULT_THERMAL_EVENT_MASKS;
            mask2_q    <= RST_MASK2;
            mask3_q    <= RST_MASK3;
            region_q   <= 4'h0;
            comp_met_q <= 3'h0;
            o_int_n    <= 1'b1;
        end else begin
            flag0_q    <= flag0_d;
            fault_thermal_event_flags_q    <= fault_thermal_event_flags_d;
            converter_event_flags_q    <= converter_event_flags_d;
            timer_fault_event_flags_q    <= timer_fault_event_flags_d;
            charge_event_masks_q    <= charge_event_masks_d;
            fault_thermal_event_masks_q    <= fault_thermal_event_masks_d;
            mask2_q    <= mask2_d;
            mask3_q    <= mask3_d;
            region_q   <= i_evt.ts_region;
            comp_met_q <= comp_met;
            o_int_n    <= int_n_d;
        end
    end

    // ==========================================================
    // Assertions
    sequence s_read_converter_event_flags;
        rd_stb && ptr_q == ADDR_CONVERTER_EVENT_FLAGS && !i_evt.adc_done && !i_evt.ts_open;
    endsequence

    sequence s_charge_event_masks_write;
        wr_stb && ptr_q == ADDR_CHARGE_EVENT_MASKS;
    endsequence

    a_ovp_flag_sticky: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        i_evt.ovp ##1 !(rd_stb && ptr_q == ADDR_FAULT_THERMAL_EVENT_FLAGS) |-> fault_thermal_event_flags_q[7] ##1 fault_thermal_event_flags_q[7])
        else $error("overvoltage flag not held");

    a_ocp_reserved_bit: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        i_evt.bat_ocp |=> fault_thermal_event_flags_q[5] && !fault_thermal_event_flags_q[6])
        else $error("overcurrent flag or reserved bit wrong");

    a_uv_flag_set: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        i_evt.bat_uv |=> fault_thermal_event_flags_q[4])
        else $error("undervoltage flag not set");

    a_cold_entry_set: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        $rose(i_evt.ts_region[3]) |-> fault_thermal_event_flags_q[3] or ##1 fault_thermal_event_flags_q[3])
        else $error("cold region entry not flagged");

    a_converter_event_flags_clear_read: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        s_read_converter_event_flags ##0 (comp_met & ~comp_met_q) == 3'h0 |=> converter_event_flags_q == 8'h00)
        else $error("converter flags not cleared by read");

    a_comp_three_cross: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (comp_met[0] && !comp_met_q[0]) |=> converter_event_flags_q[4])
        else $error("comparator three crossing not flagged");

    a_converter_event_flags_reserved: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        i_evt.ts_open |=> converter_event_flags_q[0] && converter_event_flags_q[3:1] == 3'h0)
        else $error("thermistor open flag or reserved bits wrong");

    a_wdog_flag_set: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        i_evt.wdog |=> timer_fault_event_flags_q[6] && !timer_fault_event_flags_q[7])
        else $error("watchdog flag not set");

    a_safety_flag_set: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        i_evt.safety |=> timer_fault_event_flags_q[5])
        else $error("safety timer flag not set");

    a_timer_low_bits: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_evt.wake_one && i_evt.wake_two && i_evt.rst_warn && i_evt.ilim_open && i_evt.reg_ocp)
        |=> timer_fault_event_flags_q[4:0] == 5'h1F)
        else $error("timer fault low flags not set");

    a_charge_event_masks_write: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        s_charge_event_masks_write |=> charge_event_masks_q == $past(shr_q))
        else $error("charge mask write lost");

    a_reset_values: assert property (
        @(posedge i_ref_clk)
        !i_rstn |=> converter_event_flags_q == RST_FLAG && timer_fault_event_flags_q == RST_FLAG && charge_event_masks_q == RST_CHARGE_EVENT_MASKS)
        else $error("reset values wrong");

    a_int_follows_pend: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (fault_thermal_event_flags_q[7] && !fault_thermal_event_masks_q[7]) |=> !o_int_n)
        else $error("interrupt not raised for unmasked flag");

endmodule

// *** tb/efmb_host_model.sv ***
/*
 * Host side of the two-wire register bus: a simple bus master.
 * Assumes SDA has a pull-up and that the bench clock paces every phase.
 */
`timescale 1ns/1ns

module efmb_host_model (
    input  wire logic i_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_rel
);
    // ==========================================================
    // Idle bus: both lines released
    initial begin
        o_scl     = 1'b1;
        o_sda_rel = 1'b1;
    end

    // Wait n clocks, then step just past the edge
    task automatic tk(input int n);
        repeat (n) @(posedge i_clk);
        #2;
    endtask

    // Start or repeated start: SDA falls while SCL is high
    task automatic start();
        o_sda_rel = 1'b1;
        tk(6);
        o_scl = 1'b1;
        tk(6);
        o_sda_rel = 1'b0;
        tk(6);
        o_scl = 1'b0;
        tk(1);
    endtask

    // Stop: SDA rises while SCL is high
    task automatic stop();
        o_sda_rel = 1'b0;
        tk(6);
        o_scl = 1'b1;
        tk(6);
        o_sda_rel = 1'b1;
        tk(6);
    endtask

    // One bit: data set while SCL low, sampled mid-high
    task automatic bit_io(input logic b, output logic s);
        o_sda_rel = b;
        tk(6);
        o_scl = 1'b1;
        tk(3);
        s = i_sda;
        tk(3);
        o_scl = 1'b0;
        tk(1);
    endtask

    // A byte MSB first, then the acknowledge bit
    task automatic byte_io(input logic [7:0] v, input logic last, output logic [7:0] r, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(v[i], r[i]);
        bit_io(last, s);
        ack = ~s;
    endtask

    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] dat, output logic ok);
        logic [7:0] r;
        logic       a0, a1, a2;
        start();
        byte_io({dev, 1'b0}, 1'b1, r, a0);
        byte_io(ptr, 1'b1, r, a1);
        byte_io(dat, 1'b1, r, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask

    // Pointer write, repeated start, one byte read ended by NACK
    task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] dat, output logic ok);
        logic [7:0] r;
        logic       a0, a1, a2, a3;
        start();
        byte_io({dev, 1'b0}, 1'b1, r, a0);
        byte_io(ptr, 1'b1, r, a1);
        start();
        byte_io({dev, 1'b1}, 1'b1, r, a2);
        byte_io(8'hFF, 1'b1, dat, a3);
        stop();
        ok = a0 & a1 & a2;
    endtask
endmodule

// *** tb/tb_event_flag_mask_bank.sv ***
/*
 * Self-checking bench for the event flag and mask bank.
 * Assumes the host model above and a pulled-up open-drain SDA wire.
 */
`timescale 1ns/1ns

module tb_event_flag_mask_bank
    import efmb_pkg::*;
;
    // ==========================================================
    // Signals and the reference model
    localparam logic [7:0] VALID [4] = '{8'h7F, 8'hBF, 8'h81, 8'h7F};
    logic       clk, rstn, scl, sda_rel, sda_out, sda_oe_n, int_n, ok;
    logic [7:0] rd;
    efmb_evt_t  evt;
    wire        sda = sda_rel & (sda_oe_n | sda_out);
    int         error_cnt, cmp_count, i, n, r, k, d;
    int         mflag [4];
    int         mmask [4];

    efmb_top u_efmb_top (.i_ref_clk(clk), .i_rstn(rstn), .i_evt(evt), .i_scl(scl), .i_sda(sda),
                         .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .o_int_n(int_n));
    efmb_host_model u_efmb_host_model (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_rel(sda_rel));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ==========================================================
    // Compare, verdict and watchdog
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (error_cnt == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end

    // ==========================================================
    // Register access and model helpers
    task automatic rd_chk(input int a, input int exp);
        u_efmb_host_model.read_reg(DEV_ADDR, 8'(a), rd, ok);
        check({7'h00, ok}, 8'h01);
        check(rd, 8'(exp));
    endtask

    task automatic wr(input int a, input int v);
        u_efmb_host_model.write_reg(DEV_ADDR, 8'(a), 8'(v), ok);
        if (a >= 7 && a <= 10)
            mmask[a-7] = v & 255;
    endtask

    // Interrupt is low while any flag is set and unmasked
    task automatic int_chk();
        int any;
        any = 0;
        for (int j = 0; j < 4; j++)
            any |= mflag[j] & ~mmask[j] & 255;
        check({7'h00, int_n}, {7'h00, any == 0});
    endtask

    // One-cycle event pulses for the fields of flag register fr
    task automatic pulse(input int fr, input logic [7:0] b);
        @(posedge clk);
        #2;
        case (fr)
            0: evt.charge = b[6:0];
            1: {evt.ovp, evt.bat_ocp, evt.bat_uv, evt.ts_region} = {b[7], b[5:0]};
            2: {evt.adc_done, evt.ts_open} = {b[7], b[0]};
            default: {evt.wdog, evt.safety, evt.reg_ocp, evt.ilim_open, evt.wake_one, evt.wake_two,
                      evt.rst_warn} = b[6:0];
        endcase
        mflag[fr] |= b & VALID[fr];
        @(posedge clk);
        #2;
        evt = '{comp_above: evt.comp_above, comp_dir: evt.comp_dir, default: '0};
    endtask

    // Comparator kc crosses toward its selected direction dc
    task automatic comp(input int kc, input logic dc);
        @(posedge clk);
        #2;
        {evt.comp_dir[kc], evt.comp_above[kc]} = {dc, ~dc};
        repeat (2) @(posedge clk);
        #2;
        evt.comp_above[kc] = dc;
        mflag[2] |= 1 << (kc + 4);
        repeat (3) @(posedge clk);
        #2;
        {evt.comp_dir[kc], evt.comp_above[kc]} = 2'b10;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        evt = '0;
        evt.comp_dir = 3'b111;
        rstn = 1'b0;
        error_cnt = 0;
        cmp_count = 0;
        mflag = '{default: 0};
        mmask = '{8'h00, 8'h00, 8'h71, 8'h00};
        void'($urandom(32'h2f20));
        repeat (8) @(posedge clk);
        #2;
        rstn = 1'b1;
        // Reset values, then one unmapped address
        for (i = 3; i <= 11; i++)
            rd_chk(i, (i == 9) ? 8'h71 : 8'h00);
        int_chk();
        // Mask registers keep all written bits; the converter flag register ignores writes
        for (i = 7; i <= 10; i++) begin
            wr(i, $urandom);
            rd_chk(i, mmask[i-7]);
        end
        wr(5, 8'hFF);
        rd_chk(5, 8'h00);
        // Random events under random masks, then clear on read
        for (n = 0; n < 12; n++) begin
            r = n % 4;
            wr(7 + r, $urandom);
            pulse(r, 8'($urandom));
            repeat (20) @(posedge clk);
            #2;
            int_chk();
            rd_chk(3 + r, mflag[r]);
            mflag[r] = 0;
            rd_chk(3 + r, 8'h00);
            int_chk();
        end
        // Comparator crossings in both directions
        for (k = 0; k < 3; k++)
            for (d = 0; d < 2; d++) begin
                comp(k, d[0]);
                rd_chk(5, mflag[2]);
                mflag[2] = 0;
            end
        // Foreign bus address: no acknowledge, mask untouched
        u_efmb_host_model.write_reg(DEV_ADDR ^ 7'h01, 8'h07, 8'h5A, ok);
        check({7'h00, ok}, 8'h00);
        rd_chk(7, mmask[0]);
        wrap_up();
    end
endmodule
